// *** include/branch_compare_skip_regs.vh ***
// constants for the branch, compare and skip execution unit
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef BRANCH_COMPARE_SKIP_REGS_VH
`define BRANCH_COMPARE_SKIP_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_CTRL      12'h000
`define OFS_OPCODE    12'h004
`define OFS_OPERAND   12'h008
`define OFS_PC        12'h00c
`define OFS_FLAGS     12'h010
`define OFS_SP        12'h014
`define OFS_RESULT    12'h018
`define OFS_GPR_BASE  12'h100
`define OFS_IO_BASE   12'h200
`define OFS_DMEM_BASE 12'h400

// ************************************************************
// control and result fields
// ************************************************************
`define CTRL_GO       0
`define CTRL_NEXT2    1
`define RES_BUSY      4
`define RES_TAKEN     2

// ************************************************************
// flags_ff bit positions
// ************************************************************
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
`define FL_S 4
`define FL_H 5
`define FL_T 6
`define FL_I 7

// ************************************************************
// reset values
// ************************************************************
`define RST_PC    16'h0000
`define RST_FLAGS 8'h00
`define RST_SP    16'h007f

// ************************************************************
// opcode numbers
// ************************************************************
`define OP_INDIRECT_CALL_VIA_Z        6'h01
`define OP_COMPARE_SKIP_IF_EQUAL      6'h02
`define OP_COMPARE_REGISTERS          6'h03
`define OP_COMPARE_REGISTERS_W_CARRY  6'h04
`define OP_COMPARE_WITH_IMMEDIATE     6'h05
`define OP_SKIP_IF_REG_BIT_CLEAR      6'h06
`define OP_SKIP_IF_REG_BIT_SET        6'h07
`define OP_SKIP_IF_IO_BIT_CLEAR       6'h08
`define OP_SKIP_IF_IO_BIT_SET         6'h09
`define OP_BRANCH_STATUS_BIT_SET      6'h0a
`define OP_BRANCH_STATUS_BIT_CLEAR    6'h0b
`define OP_BRANCH_IF_EQUAL            6'h0c
`define OP_BRANCH_IF_NOT_EQUAL        6'h0d
`define OP_BRANCH_IF_CARRY_SET        6'h0e
`define OP_BRANCH_IF_CARRY_CLEAR      6'h0f
`define OP_BRANCH_SAME_OR_HIGHER      6'h10
`define OP_BRANCH_IF_LOWER            6'h11
`define OP_BRANCH_IF_MINUS            6'h12
`define OP_BRANCH_IF_PLUS             6'h13
`define OP_BRANCH_SIGNED_GE           6'h14
`define OP_BRANCH_SIGNED_LT           6'h15
`define OP_BRANCH_HALF_CARRY_SET      6'h16
`define OP_BRANCH_HALF_CARRY_CLEAR    6'h17
`define OP_BRANCH_TRANSFER_BIT_SET    6'h18
`define OP_BRANCH_TRANSFER_BIT_CLEAR  6'h19
`define OP_BRANCH_OVERFLOW_SET        6'h1a
`define OP_BRANCH_OVERFLOW_CLEAR      6'h1b
`define OP_BRANCH_IRQ_ENABLED         6'h1c
`define OP_BRANCH_IRQ_DISABLED        6'h1d
`define OP_LOAD_INDIRECT_X_POSTINC    6'h1e
`define OP_LOAD_INDIRECT_X_PREDEC     6'h1f

// ************************************************************
// cycle counts
// ************************************************************
`define CYC_CALL   2'd3
`define CYC_LOAD   2'd2
`define CYC_ONE    2'd1

`endif

// *** rtl/branch_compare_skip_unit.v ***
// execution unit for compare, skip, relative branch, indirect call
// and X-pointer loads of an 8-bit core; software drives it over
// classic wishbone, all state lives in the flops below.
// How it works
// - indirect call: pc from Z, push return address, flags kept, 3 cycles
// - compare-skip: equal registers skip next, nothing altered, 1/2/3 cycles
// - a taken skip adds 2 or 3 to pc instead of 1
// - compares subtract, drop result, set Z N V C H, one cycle
// - register-bit skips test a register bit, clear or set variant
// - io-bit skips test an io register bit, 1/2/3 cycles
// - generic branches test a chosen flag, target pc plus k plus one
// - branch on zero flag clear or set
// - branch on carry clear or set, including the aliases
// - same-or-higher equals carry-clear in condition and target
// - branch on negative flag set or clear
// - signed branches use negative xor overflow
// - branch on half-carry set or clear
// - branch on transfer bit set or clear, 1 or 2 cycles
// - branch on overflow set or clear, flags unchanged
// - branch on global interrupt enable set or clear
// - load via X then increment X, 2 cycles, flags kept
// - decrement X then load via new X, 2 cycles, flags kept
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "branch_compare_skip_regs.vh"

module branch_compare_skip_unit #(
    parameter DM_AW = 7
) (
    // clock, reset, enable
    input  wire        CLK,
    input  wire        RESET,
    input  wire        CE,
    // wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [3:0]  SEL_I,
    input  wire [11:0] ADR_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O
);

    localparam DM_DEPTH = 1 << DM_AW;
    localparam ST_IDLE  = 2'b01;
    localparam ST_EXEC  = 2'b10;

    // ************************************************************
    // architectural state
    // ************************************************************
    reg [7:0]  gpr_ff  [0:31];
    reg [7:0]  io_ff   [0:31];
    reg [7:0]  dmem_ff [0:DM_DEPTH-1];
    reg [15:0] pc_ff;
    reg [7:0]  flags_ff;
    reg [15:0] sp_ff;
    reg [5:0]  opcode_ff;
    reg [23:0] operand_ff;
    reg        next2_ff;
    reg [1:0]  state_ff;
    reg [1:0]  cnt_ff;
    reg [1:0]  last_cyc_ff;
    reg        last_taken_ff;

    // ************************************************************
    // operand fields
    // ************************************************************
    wire [4:0]  rd_idx  = operand_ff[4:0];
    wire [4:0]  rr_idx  = operand_ff[12:8];
    wire [7:0]  imm     = operand_ff[23:16];
    wire [2:0]  bit_sel = operand_ff[18:16];
    wire [2:0]  flag_sel = operand_ff[2:0];
    wire [7:0]  vd      = gpr_ff[rd_idx];
    wire [7:0]  vr      = gpr_ff[rr_idx];
    wire [7:0]  vio     = io_ff[rr_idx];
    wire [15:0] ptr_x   = {gpr_ff[27], gpr_ff[26]};
    wire [15:0] ptr_z   = {gpr_ff[31], gpr_ff[30]};
    wire [15:0] pc_inc  = pc_ff + 16'h0001;

    // ************************************************************
    // compare datapath
    // ************************************************************
    wire       use_imm = (opcode_ff == `OP_COMPARE_WITH_IMMEDIATE);
    wire       use_cin = (opcode_ff == `OP_COMPARE_REGISTERS_W_CARRY);
    wire [7:0] sub_b   = use_imm ? imm : vr;
    wire       cin     = use_cin & flags_ff[`FL_C];
    // ninth bit only widens the subtraction, the result is dropped
    wire [8:0] diff    = {1'b0, vd} - {1'b0, sub_b} - {8'h00, cin};
    wire [7:0] res     = diff[7:0];
    wire cmp_h = (~vd[3] & sub_b[3]) | (sub_b[3] & res[3]) | (res[3] & ~vd[3]);
    wire cmp_v = (vd[7] & ~sub_b[7] & ~res[7]) | (~vd[7] & sub_b[7] & res[7]);
    wire cmp_c = (~vd[7] & sub_b[7]) | (sub_b[7] & res[7]) | (res[7] & ~vd[7]);
    // with carry-in, zero only survives if it held before
    wire cmp_z = (res == 8'h00) & (~use_cin | flags_ff[`FL_Z]);

    // ************************************************************
    // decode: class and condition
    // ************************************************************
    reg        is_cmp;
    reg        is_skip;
    reg        is_br;
    reg        is_call;
    reg        is_load;
    reg        cond;
    reg        br_flag;
    reg        br_want;

    // condition per opcode; aliases share one arm on purpose
    always @* begin
        is_cmp  = 1'b0;
        is_skip = 1'b0;
        is_call = 1'b0;
        is_load = 1'b0;
        cond    = 1'b0;
        br_flag = 1'b0;
        br_want = ~opcode_ff[0]; // odd opcodes test for a clear flag
        case (opcode_ff)
            `OP_INDIRECT_CALL_VIA_Z: begin
                is_call = 1'b1;
            end
            `OP_COMPARE_SKIP_IF_EQUAL: begin
                is_skip = 1'b1;
                cond    = (vd == vr);
            end
            `OP_COMPARE_REGISTERS,
            `OP_COMPARE_REGISTERS_W_CARRY,
            `OP_COMPARE_WITH_IMMEDIATE: begin
                is_cmp = 1'b1;
            end
            `OP_SKIP_IF_REG_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond    = ~vr[bit_sel];
            end
            `OP_SKIP_IF_REG_BIT_SET: begin
                is_skip = 1'b1;
                cond    = vr[bit_sel];
            end
            `OP_SKIP_IF_IO_BIT_CLEAR: begin
                is_skip = 1'b1;
                cond    = ~vio[bit_sel];
            end
            `OP_SKIP_IF_IO_BIT_SET: begin
                is_skip = 1'b1;
                cond    = vio[bit_sel];
            end
            `OP_BRANCH_STATUS_BIT_SET,
            `OP_BRANCH_STATUS_BIT_CLEAR: begin
                br_flag = flags_ff[flag_sel];
            end
            `OP_BRANCH_IF_EQUAL,
            `OP_BRANCH_IF_NOT_EQUAL: begin
                br_flag = flags_ff[`FL_Z];
            end
            `OP_BRANCH_IF_CARRY_SET,
            `OP_BRANCH_IF_CARRY_CLEAR: begin
                br_flag = flags_ff[`FL_C];
            end
            // alias pair lists the clear test first, so polarity flips
            `OP_BRANCH_SAME_OR_HIGHER,
            `OP_BRANCH_IF_LOWER: begin
                br_flag = flags_ff[`FL_C];
                br_want = opcode_ff[0];
            end
            `OP_BRANCH_IF_MINUS,
            `OP_BRANCH_IF_PLUS: begin
                br_flag = flags_ff[`FL_N];
            end
            `OP_BRANCH_SIGNED_GE,
            `OP_BRANCH_SIGNED_LT: begin
                br_flag = flags_ff[`FL_N] ^ flags_ff[`FL_V];
                br_want = opcode_ff[0];
            end
            `OP_BRANCH_HALF_CARRY_SET,
            `OP_BRANCH_HALF_CARRY_CLEAR: begin
                br_flag = flags_ff[`FL_H];
            end
            `OP_BRANCH_TRANSFER_BIT_SET,
            `OP_BRANCH_TRANSFER_BIT_CLEAR: begin
                br_flag = flags_ff[`FL_T];
            end
            `OP_BRANCH_OVERFLOW_SET,
            `OP_BRANCH_OVERFLOW_CLEAR: begin
                br_flag = flags_ff[`FL_V];
            end
            `OP_BRANCH_IRQ_ENABLED,
            `OP_BRANCH_IRQ_DISABLED: begin
                br_flag = flags_ff[`FL_I];
            end
            `OP_LOAD_INDIRECT_X_POSTINC,
            `OP_LOAD_INDIRECT_X_PREDEC: begin
                is_load = 1'b1;
            end
            default: cond = 1'b0; // unknown opcode: one-cycle no-op
        endcase
        // relative branches occupy one contiguous opcode range
        is_br = (opcode_ff >= `OP_BRANCH_STATUS_BIT_SET)
              & (opcode_ff <= `OP_BRANCH_IRQ_DISABLED);
        if (is_br) begin
            cond = (br_flag == br_want);
        end
    end

    // ************************************************************
    // next pc, pointer, cycle count
    // ************************************************************
    wire [15:0] k_ext  = {{9{imm[6]}}, imm[6:0]};
    wire [15:0] br_tgt = pc_inc + k_ext; // pc + k + 1
    // next2 (or a go write's own bit) sizes the passed-over instruction
    wire        next2_now = state_ff[0] ? DAT_I[`CTRL_NEXT2] : next2_ff;
    wire [15:0] skip_pc = pc_ff + (next2_now ? 16'h0003 : 16'h0002);
    wire        predec  = (opcode_ff == `OP_LOAD_INDIRECT_X_PREDEC);
    wire [15:0] ld_addr = predec ? ptr_x - 16'h0001 : ptr_x;
    wire [15:0] x_after = predec ? ld_addr : ptr_x + 16'h0001;
    wire [15:0] sp_lo   = sp_ff - 16'h0001;
    reg  [15:0] nxt_pc;
    reg  [1:0]  nxt_cyc;

    // pc and duration selection
    always @* begin
        nxt_pc  = pc_inc;
        nxt_cyc = `CYC_ONE;
        if (is_call) begin
            nxt_pc  = ptr_z;
            nxt_cyc = `CYC_CALL;
        end else if (is_load) begin
            nxt_cyc = `CYC_LOAD;
        end else if (is_skip && cond) begin
            nxt_pc  = skip_pc;
            nxt_cyc = next2_now ? 2'd3 : 2'd2;
        end else if (is_br && cond) begin
            nxt_pc  = br_tgt;
            nxt_cyc = 2'd2;
        end
    end

    // ************************************************************
    // wishbone decode
    // ************************************************************
    wire        req     = CYC_I & STB_I & ~ACK_O;
    wire        idle    = state_ff[0];
    wire        wr_ok   = req & WE_I & idle; // state is frozen while busy
    wire        in_gpr  = (ADR_I[11:7] == 5'h02);
    wire        in_io   = (ADR_I[11:7] == 5'h04);
    wire        in_dmem = (ADR_I[11:10] == 2'b01)
                        && (ADR_I[9:2] < DM_DEPTH);
    wire [4:0]  widx    = ADR_I[6:2];
    wire [DM_AW-1:0] didx = ADR_I[DM_AW+1:2];
    wire        go      = wr_ok & (ADR_I == `OFS_CTRL) & SEL_I[0]
                        & DAT_I[`CTRL_GO];
    reg  [31:0] rd_mux;

    // read mux; unmapped words read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (ADR_I)
            `OFS_CTRL:    rd_mux = {30'h0, next2_ff, 1'b0};
            `OFS_OPCODE:  rd_mux = {26'h0, opcode_ff};
            `OFS_OPERAND: rd_mux = {8'h00, operand_ff};
            `OFS_PC:      rd_mux = {16'h0000, pc_ff};
            `OFS_FLAGS:   rd_mux = {24'h000000, flags_ff};
            `OFS_SP:      rd_mux = {16'h0000, sp_ff};
            `OFS_RESULT:  rd_mux = {27'h0, ~idle, 1'b0, last_taken_ff,
                                    last_cyc_ff};
            default: begin
                if (in_gpr) begin
                    rd_mux = {24'h000000, gpr_ff[widx]};
                end else if (in_io) begin
                    rd_mux = {24'h000000, io_ff[widx]};
                end else if (in_dmem) begin
                    rd_mux = {24'h000000, dmem_ff[didx]};
                end
            end
        endcase
    end

    // ************************************************************
    // bus answer: one wait state, ack for one cycle
    // ************************************************************
    always @(posedge CLK) begin
        if (RESET) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else if (CE) begin
            ACK_O <= req;
            DAT_O <= req ? rd_mux : 32'h0000_0000;
        end
    end

    // ************************************************************
    // sequencer and control registers
    // ************************************************************
    always @(posedge CLK) begin
        if (RESET) begin
            state_ff      <= ST_IDLE;
            cnt_ff        <= 2'd0;
            pc_ff         <= `RST_PC;
            flags_ff      <= `RST_FLAGS;
            sp_ff         <= `RST_SP;
            opcode_ff     <= 6'h00;
            operand_ff    <= 24'h000000;
            next2_ff      <= 1'b0;
            last_cyc_ff   <= 2'd0;
            last_taken_ff <= 1'b0;
        end else if (CE) begin
            case (state_ff)
                ST_IDLE: begin
                    if (wr_ok) begin
                        case (ADR_I)
                            `OFS_CTRL:
                                if (SEL_I[0]) next2_ff <= DAT_I[`CTRL_NEXT2];
                            `OFS_OPCODE:
                                if (SEL_I[0]) opcode_ff <= DAT_I[5:0];
                            `OFS_OPERAND: begin
                                if (SEL_I[0]) operand_ff[7:0]   <= DAT_I[7:0];
                                if (SEL_I[1]) operand_ff[15:8]  <= DAT_I[15:8];
                                if (SEL_I[2]) operand_ff[23:16] <= DAT_I[23:16];
                            end
                            `OFS_PC: begin
                                if (SEL_I[0]) pc_ff[7:0]  <= DAT_I[7:0];
                                if (SEL_I[1]) pc_ff[15:8] <= DAT_I[15:8];
                            end
                            `OFS_FLAGS:
                                if (SEL_I[0]) flags_ff <= DAT_I[7:0];
                            `OFS_SP: begin
                                if (SEL_I[0]) sp_ff[7:0]  <= DAT_I[7:0];
                                if (SEL_I[1]) sp_ff[15:8] <= DAT_I[15:8];
                            end
                            default: cnt_ff <= cnt_ff;
                        endcase
                    end
                    if (go) begin
                        state_ff <= ST_EXEC;
                        cnt_ff   <= nxt_cyc - 2'd1;
                    end
                end
                ST_EXEC: begin
                    if (cnt_ff != 2'd0) begin
                        cnt_ff <= cnt_ff - 2'd1;
                    end else begin
                        // commit on the last cycle; operands stayed frozen
                        state_ff      <= ST_IDLE;
                        pc_ff         <= nxt_pc;
                        last_cyc_ff   <= nxt_cyc;
                        last_taken_ff <= (is_skip | is_br) & cond;
                        if (is_cmp) begin
                            flags_ff[`FL_Z] <= cmp_z;
                            flags_ff[`FL_N] <= res[7];
                            flags_ff[`FL_V] <= cmp_v;
                            flags_ff[`FL_C] <= cmp_c;
                            flags_ff[`FL_H] <= cmp_h;
                        end
                        if (is_call) begin
                            sp_ff <= sp_ff - 16'h0002;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // register file, io image and data memory writes
    // ************************************************************
    wire commit = state_ff[1] & (cnt_ff == 2'd0);

    always @(posedge CLK) begin
        if (CE) begin
            if (wr_ok && SEL_I[0]) begin
                if (in_gpr) gpr_ff[widx] <= DAT_I[7:0];
                if (in_io) io_ff[widx] <= DAT_I[7:0];
                if (in_dmem) dmem_ff[didx] <= DAT_I[7:0];
            end
            if (commit && is_call) begin
                // return address, low byte at sp, high byte below it
                dmem_ff[sp_ff[DM_AW-1:0]] <= pc_inc[7:0];
                dmem_ff[sp_lo[DM_AW-1:0]] <= pc_inc[15:8];
            end
            if (commit && is_load) begin
                // pointer first, so a load into r26/r27 wins over it
                gpr_ff[26] <= x_after[7:0];
                gpr_ff[27] <= x_after[15:8];
                gpr_ff[rd_idx] <= dmem_ff[ld_addr[DM_AW-1:0]];
            end
        end
    end

endmodule
`default_nettype wire

// *** testbench/branch_compare_skip_unit_asserts.sv ***
// checker for the wishbone port of the execution unit
// assumes a classic single-cycle master and CE mostly high
`timescale 1ns/1ps
`default_nettype none
`include "branch_compare_skip_regs.vh"
module branch_compare_skip_unit_asserts #(
    parameter DM_AW = 7
) (
    // clock, reset, enable
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        CE,
    // wishbone
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [11:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O
);
    // ****************
    // bus timing
    // ****************
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // a request is taken only while no ack is out
    sequence s_take;
        CE && CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_rd(a);
        s_take ##0 !WE_I && ADR_I == a;
    endsequence
    property p_ack_wait;
        s_take |=> ACK_O;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("no ack");
    property p_ack_pulse;
        CE && ACK_O |=> !ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_ack_cause;
        ACK_O && !$past(ACK_O) |-> $past(CYC_I && STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_dat_idle;
        !ACK_O |-> DAT_O == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data idle");
    // a low enable must freeze the bus side too
    property p_freeze;
        !CE |=> $stable(ACK_O) && $stable(DAT_O);
    endproperty
    a_freeze: assert property (p_freeze) else $error("not frozen");
    property p_reset;
        disable iff (1'b0) RESET && CE |=> !ACK_O && DAT_O == 32'h0;
    endproperty
    a_reset: assert property (p_reset) else $error("reset bus");
    property p_ctrl_rd;
        s_rd(`OFS_CTRL) |=> DAT_O[0] == 1'b0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("go reads 1");
    property p_flags_rd;
        s_rd(`OFS_FLAGS) |=> DAT_O[31:8] == 24'h0;
    endproperty
    a_flags_rd: assert property (p_flags_rd) else $error("flags high");
    property p_pc_rd;
        s_rd(`OFS_PC) |=> DAT_O[31:16] == 16'h0;
    endproperty
    a_pc_rd: assert property (p_pc_rd) else $error("pc high");
endmodule
bind branch_compare_skip_unit branch_compare_skip_unit_asserts #(
    .DM_AW(DM_AW)) branch_compare_skip_unit_asserts_i (.CLK(CLK),
    .RESET(RESET), .CE(CE), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O));
`default_nettype wire

// *** testbench/wb_host_model.sv ***
// software side of the unit: classic wishbone single cycles
// assumes the slave acks each request within the bench timeout
`timescale 1ns/1ps
`default_nettype none
module wb_host_model (
    // clock
    input  wire logic        clk,
    // wishbone master
    output var  logic        cyc,
    output var  logic        stb,
    output var  logic        we,
    output var  logic [11:0] adr,
    output var  logic [31:0] dat_w,
    input  wire logic [31:0] dat_r,
    input  wire logic        ack
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h0;
        dat_w = 32'h0;
    end
    // request held until ack is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/branch_compare_skip_unit_test.sv ***
// self-checking bench of the execution unit
// assumes the register map and cycle counts of the unit's header
`timescale 1ns/1ps
`default_nettype none
`include "branch_compare_skip_regs.vh"
module branch_compare_skip_unit_test;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic        cyc, stb, we, ack;
    logic [11:0] adr;
    logic [31:0] dw, dr;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #25 clk = ~clk;
    wb_host_model wb_host_model_i (.clk(clk), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .dat_w(dw), .dat_r(dr), .ack(ack));
    branch_compare_skip_unit branch_compare_skip_unit_i (.CLK(clk),
        .RESET(reset), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .SEL_I(4'hf), .ADR_I(adr), .DAT_I(dw), .DAT_O(dr), .ACK_O(ack));
    // ****************
    // helpers
    // ****************
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_host_model_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rv(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_host_model_i.xfer(1'b0, a, 32'h0, q);
        num_checks++;
        if (q !== e) begin
            miscompares++;
            $display("Error %0t: at %h got %h want %h", $time, a, q, e);
        end
    endtask
    function automatic logic [11:0] g(input logic [6:0] n, logic [11:0] b);
        return b + {3'h0, n, 2'b00};
    endfunction
    // start one instruction and wait out busy
    task automatic run(input logic [5:0] op, input logic [23:0] o,
        input logic n2);
        logic [31:0] q;
        wr(`OFS_OPCODE, {26'h0, op});
        wr(`OFS_OPERAND, {8'h0, o});
        wr(`OFS_CTRL, {30'h0, n2, 1'b1});
        do wb_host_model_i.xfer(1'b0, `OFS_RESULT, 32'h0, q);
        while (q[4] !== 1'b0);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_compare;
        wr(g(1, `OFS_GPR_BASE), 32'h10);
        wr(g(2, `OFS_GPR_BASE), 32'h20);
        wr(g(3, `OFS_GPR_BASE), 32'h10);
        run(`OP_COMPARE_REGISTERS, 24'h000201, 1'b0);
        rv(`OFS_FLAGS, 32'h05);
        rv(`OFS_RESULT, 32'h1);
        run(`OP_COMPARE_REGISTERS_W_CARRY, 24'h000101, 1'b0);
        rv(`OFS_FLAGS, 32'h25);
        run(`OP_COMPARE_WITH_IMMEDIATE, 24'h100001, 1'b0);
        rv(`OFS_FLAGS, 32'h02);
        rv(g(1, `OFS_GPR_BASE), 32'h10);
        rv(`OFS_PC, 32'h3);
        $display("compare done");
    endtask
    task automatic t_skip;
        run(`OP_COMPARE_SKIP_IF_EQUAL, 24'h000301, 1'b1);
        rv(`OFS_PC, 32'h6);
        rv(`OFS_RESULT, 32'h7);
        rv(`OFS_FLAGS, 32'h02);
        run(`OP_SKIP_IF_REG_BIT_CLEAR, 24'h000101, 1'b0);
        rv(`OFS_PC, 32'h8);
        wr(g(3, `OFS_IO_BASE), 32'h08);
        run(`OP_SKIP_IF_IO_BIT_SET, 24'h030303, 1'b0);
        rv(`OFS_RESULT, 32'h6);
        run(`OP_SKIP_IF_IO_BIT_SET, 24'h020303, 1'b0);
        rv(`OFS_PC, 32'hb);
        run(`OP_SKIP_IF_REG_BIT_SET, 24'h040100, 1'b0);
        rv(`OFS_PC, 32'hd);
        run(`OP_SKIP_IF_IO_BIT_CLEAR, 24'h030300, 1'b1);
        rv(`OFS_RESULT, 32'h1);
        $display("skip done");
    endtask
    task automatic t_branch;
        logic [7:0] mk [10] = '{8'h40, 8'h02, 8'h01, 8'h01, 8'h04,
            8'h04, 8'h20, 8'h40, 8'h08, 8'h80};
        logic [7:0] tk;
        logic [7:0] fl;
        for (int i = 0; i < 20; i++) begin
            tk = (i[0] != (i / 2 == 3 || i / 2 == 5)) ? 8'h0 : mk[i / 2];
            for (int n = 0; n < 2; n++) begin
                fl = tk ^ (n ? mk[i / 2] : 8'h0);
                wr(`OFS_PC, 32'h40);
                wr(`OFS_FLAGS, {24'h0, fl});
                run(6'(`OP_BRANCH_STATUS_BIT_SET + i), 24'h7d0006, 1'b0);
                rv(`OFS_PC, n ? 32'h41 : 32'h3e);
                rv(`OFS_RESULT, n ? 32'h1 : 32'h6);
                rv(`OFS_FLAGS, {24'h0, fl});
            end
        end
        $display("branch done");
    endtask
    task automatic t_call_load;
        wr(g(30, `OFS_GPR_BASE), 32'h23);
        wr(g(31, `OFS_GPR_BASE), 32'h01);
        wr(`OFS_PC, 32'h10);
        run(`OP_INDIRECT_CALL_VIA_Z, 24'h0, 1'b0);
        rv(`OFS_PC, 32'h123);
        rv(`OFS_SP, 32'h7d);
        rv(`OFS_FLAGS, 32'h80);
        rv(g(7'h7e, `OFS_DMEM_BASE), 32'h0);
        rv(g(7'h7f, `OFS_DMEM_BASE), 32'h11);
        rv(`OFS_RESULT, 32'h3);
        wr(g(26, `OFS_GPR_BASE), 32'h10);
        wr(g(27, `OFS_GPR_BASE), 32'h0);
        wr(g(7'h10, `OFS_DMEM_BASE), 32'ha5);
        run(`OP_LOAD_INDIRECT_X_POSTINC, 24'h000005, 1'b0);
        rv(g(5, `OFS_GPR_BASE), 32'ha5);
        rv(g(26, `OFS_GPR_BASE), 32'h11);
        run(`OP_LOAD_INDIRECT_X_PREDEC, 24'h000006, 1'b0);
        rv(g(6, `OFS_GPR_BASE), 32'ha5);
        rv(`OFS_RESULT, 32'h2);
        rv(g(26, `OFS_GPR_BASE), 32'h10);
        rv(`OFS_FLAGS, 32'h80);
        $display("call and load done");
    endtask
    // hang guard well above the under 1500 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_compare();
        t_skip();
        t_branch();
        t_call_load();
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        rv(12'h030, 32'h0);
        rv(`OFS_CTRL, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
